// ---- bench/gdm_master_model.sv ----
// gdm_master_model: register-bus master standing in for the control system.
// assumes the map answers one cycle after a request's last word; drives on falling edges.
module gdm_master_model
  import gdm_pkg::*;
(
  input  wire logic        clk,
  input  wire gdm_rsp_type rsp,
  output gdm_req_type      req
);
  timeunit 1ns;
  timeprecision 1ns;

  initial req = '0;

  // one word, reply taken at the next falling edge
  task automatic single(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
                        output gdm_rsp_type r);
    @(negedge clk);
    req = '{1'b1, f, a, d, 1'b1, 1'b1};
    @(negedge clk);
    r = rsp;
    req = '0;
  endtask

  // six words back to back; early counts replies seen before the last word
  task automatic multi(input logic [15:0] a, input logic [15:0] v [6],
                       output gdm_rsp_type r, output int early);
    early = 0;
    for (int i = 0; i < 6; i++) begin
      @(negedge clk);
      if (i > 0 && rsp.valid === 1'b1) early++;
      req = '{1'b1, FN_WR_MULTI, a + 16'(i), v[i], i == 0, i == 5};
    end
    @(negedge clk);
    r = rsp;
    req = '0;
  endtask
endmodule

// ---- bench/testbench.sv ----
// testbench: self-checking bench for the detector register map.
// assumes the map and master model; tick period outlasts the register tests.
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin err_count++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module testbench
  import gdm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int TICK = 2000;

  logic         clk;
  logic         rst;
  gdm_req_type  req;
  gdm_rsp_type  rsp;
  logic [31:0]  gas_a_ppm;
  logic [31:0]  gas_b_ppm;
  logic [15:0]  ext_words [NUM_EXT];
  logic [15:0]  lg_day;
  logic [15:0]  lg_hour;
  logic [15:0]  lg_min;
  logic [15:0]  lg_sec;
  gdm_time_type rtc;
  logic [15:0]  forced_loop_current;
  gdm_time_type t_exp;
  gdm_rsp_type  r;
  logic [15:0]  v [6];
  int           early;
  int           err_count;
  int           tests_run;

  gdm_register_map #(.IS_RECEIVER(1'b1), .TICK_CYCLES(TICK)) uut (
    .clk                       (clk),
    .rst                       (rst),
    .req                       (req),
    .rsp                       (rsp),
    .gas_a_ppm                 (gas_a_ppm),
    .gas_b_ppm                 (gas_b_ppm),
    .ext_words                 (ext_words),
    .laser_one_last_gas_day    (lg_day),
    .laser_one_last_gas_hour   (lg_hour),
    .laser_one_last_gas_minute (lg_min),
    .laser_one_last_gas_second (lg_sec),
    .rtc                       (rtc),
    .forced_loop_current       (forced_loop_current)
  );

  gdm_master_model master (
    .clk (clk),
    .rsp (rsp),
    .req (req)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // one request, reply judged
  task automatic op(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
                    input logic [7:0] code, input logic [15:0] data);
    master.single(f, a, d, r);
    `CHK("rsp_valid", 1'b1, r.valid);
    `CHK("rsp_code", code, r.code);
    `CHK("rsp_exc", code != EXC_NONE, r.exc);
    if (code == EXC_NONE) `CHK("rsp_data", data, r.data);
  endtask

  task automatic t_reset();
    t_exp = '{16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000};
    `CHK("rtc", t_exp, rtc);
    `CHK("loop", 16'h0000, forced_loop_current);
    `CHK("rsp_idle", 26'h0, rsp);
    for (int i = 1; i <= NUM_HOLD; i++)
      op(FN_RD_HOLD, 16'(i), 16'h0000, EXC_NONE, HOLD_RST[i]);
  endtask

  // upper bound of every holding register, lower bound of month and day
  task automatic t_ranges();
    logic [15:0] ad [9]  = '{16'h0001, 16'h0002, 16'h0002, 16'h0003, 16'h0003,
                             16'h0004, 16'h0005, 16'h0006, 16'h0007};
    logic [15:0] ok [9]  = '{16'h00C8, 16'h000C, 16'h0001, 16'h001F, 16'h0001,
                             16'h0017, 16'h003B, 16'h003B, 16'h5208};
    logic [15:0] bad [9] = '{16'h00C9, 16'h000D, 16'h0000, 16'h0020, 16'h0000,
                             16'h0018, 16'h003C, 16'h003C, 16'h5209};
    for (int i = 0; i < 9; i++) begin
      op(FN_WR_SINGLE, ad[i], ok[i], EXC_NONE, ok[i]);
      op(FN_WR_SINGLE, ad[i], bad[i], EXC_ILL_VALUE, 16'h0000);
      op(FN_RD_HOLD, ad[i], 16'h0000, EXC_NONE, ok[i]);
    end
    t_exp = '{16'h00C8, 16'h0001, 16'h0001, 16'h0017, 16'h003B, 16'h003B};
    `CHK("rtc", t_exp, rtc);
    `CHK("loop", 16'h5208, forced_loop_current);
  endtask

  // whole date/time block, then one with a bad last word
  task automatic t_multi();
    v = '{16'h0018, 16'h0002, 16'h001C, 16'h000B, 16'h001E, 16'h002D};
    t_exp = {v[0], v[1], v[2], v[3], v[4], v[5]};
    master.multi(HR_YEAR, v, r, early);
    `CHK("early", 0, early);
    `CHK("rsp_code", EXC_NONE, r.code);
    `CHK("rtc", t_exp, rtc);
    v[0] = 16'h0005;
    v[5] = 16'h003C;
    master.multi(HR_YEAR, v, r, early);
    `CHK("rsp_code", EXC_ILL_VALUE, r.code);
    `CHK("rtc", t_exp, rtc);
  endtask

  task automatic t_inputs();
    op(FN_RD_INPUT, IR_GAS_A, 16'h0000, EXC_NONE, GAS_SAT);
    op(FN_RD_INPUT, IR_GAS_B, 16'h0000, EXC_NONE, 16'hFFFE);
    gas_a_ppm = 32'h0000FFFF;
    op(FN_RD_INPUT, IR_GAS_A, 16'h0000, EXC_NONE, 16'hFFFF);
    for (int i = 0; i < NUM_EXT; i++)
      op(FN_RD_INPUT, IR_EXT_FIRST + 16'(i), 16'h0000, EXC_NONE, ext_words[i]);
    op(FN_RD_INPUT, IR_L1_GAS_DAY, 16'h0000, EXC_NONE, lg_day);
    op(FN_RD_INPUT, IR_L1_GAS_HOUR, 16'h0000, EXC_NONE, lg_hour);
    op(FN_RD_INPUT, IR_L1_GAS_MIN, 16'h0000, EXC_NONE, lg_min);
    op(FN_RD_INPUT, IR_L1_GAS_SEC, 16'h0000, EXC_NONE, lg_sec);
    op(FN_RD_INPUT, 16'h0003, 16'h0000, EXC_ILL_ADDR, 16'h0000);
  endtask

  task automatic t_refuse();
    op(FN_WR_SINGLE, IR_L1_GAS_DAY, 16'h0002, EXC_ILL_ADDR, 16'h0000);
    op(FN_RD_INPUT, IR_L1_GAS_DAY, 16'h0000, EXC_NONE, lg_day);
    op(FN_WR_SINGLE, 16'h0008, 16'h0001, EXC_ILL_ADDR, 16'h0000);
    op(FN_RD_HOLD, 16'h0008, 16'h0000, EXC_ILL_ADDR, 16'h0000);
    op(8'h05, HR_YEAR, 16'h0001, EXC_ILL_FUNC, 16'h0000);
    v = '{16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0001};
    master.multi(IR_EXT_FIRST, v, r, early);
    `CHK("rsp_code", EXC_ILL_ADDR, r.code);
    `CHK("rtc", t_exp, rtc);
    `CHK("loop", 16'h5208, forced_loop_current);
  endtask

  // running clock crosses a month end, then steps one second
  task automatic t_tick();
    v = '{16'h0003, 16'h0002, 16'h001C, 16'h0017, 16'h003B, 16'h003B};
    master.multi(HR_YEAR, v, r, early);
    `CHK("rsp_code", EXC_NONE, r.code);
    for (int n = 0; n < TICK + 10 && rtc.second == 16'h003B; n++) @(negedge clk);
    t_exp = '{16'h0003, 16'h0003, 16'h0001, 16'h0000, 16'h0000, 16'h0000};
    `CHK("rtc_roll", t_exp, rtc);
    for (int n = 0; n < TICK + 10 && rtc.second == 16'h0000; n++) @(negedge clk);
    `CHK("rtc_second", 16'h0001, rtc.second);
  endtask

  task automatic give_verdict();
    $display("checks run %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    err_count = 0;
    tests_run = 0;
    rst = 1'b1;
    gas_a_ppm = 32'h00010000;
    gas_b_ppm = 32'h0000FFFE;
    for (int i = 0; i < NUM_EXT; i++) ext_words[i] = 16'h0A00 + 16'(i);
    lg_day = 16'h001F;
    lg_hour = 16'h0017;
    lg_min = 16'h003B;
    lg_sec = 16'h0009;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_ranges();
    t_multi();
    t_inputs();
    t_refuse();
    t_tick();
    give_verdict();
  end

  // watchdog: the tests need about two tick periods
  initial begin
    repeat (8000) @(posedge clk);
    err_count++;
    give_verdict();
  end
endmodule

// ---- pkg/gdm_pkg.sv ----
// gdm_pkg: constants and carrier types for the gas detector register map.
// assumes a single 10 MHz clock and one request per cycle at most.
package gdm_pkg;

  // function codes
  localparam logic [7:0] FN_RD_HOLD   = 8'h03;
  localparam logic [7:0] FN_RD_INPUT  = 8'h04;
  localparam logic [7:0] FN_WR_SINGLE = 8'h06;
  localparam logic [7:0] FN_WR_MULTI  = 8'h10;

  // exception codes
  localparam logic [7:0] EXC_NONE      = 8'h00;
  localparam logic [7:0] EXC_ILL_FUNC  = 8'h01;
  localparam logic [7:0] EXC_ILL_ADDR  = 8'h02;
  localparam logic [7:0] EXC_ILL_VALUE = 8'h03;

  // holding register numbers
  localparam logic [15:0] HR_YEAR   = 16'h0001;
  localparam logic [15:0] HR_MONTH  = 16'h0002;
  localparam logic [15:0] HR_DAY    = 16'h0003;
  localparam logic [15:0] HR_HOUR   = 16'h0004;
  localparam logic [15:0] HR_MINUTE = 16'h0005;
  localparam logic [15:0] HR_SECOND = 16'h0006;
  localparam logic [15:0] HR_LOOP   = 16'h0007;
  localparam int          NUM_HOLD  = 7;

  // input register numbers
  localparam logic [15:0] IR_GAS_A       = 16'h0001;
  localparam logic [15:0] IR_GAS_B       = 16'h0002;
  localparam logic [15:0] IR_EXT_FIRST   = 16'h000C;
  localparam logic [15:0] IR_EXT_LAST    = 16'h0013;
  localparam logic [15:0] IR_L1_GAS_DAY  = 16'h0026;
  localparam logic [15:0] IR_L1_GAS_HOUR = 16'h0027;
  localparam logic [15:0] IR_L1_GAS_MIN  = 16'h0028;
  localparam logic [15:0] IR_L1_GAS_SEC  = 16'h0029;
  localparam int          NUM_EXT        = 8;

  // value limits
  localparam logic [15:0] YEAR_MAX    = 16'h00C8;
  localparam logic [15:0] MONTH_MIN   = 16'h0001;
  localparam logic [15:0] MONTH_MAX   = 16'h000C;
  localparam logic [15:0] DAY_MIN     = 16'h0001;
  localparam logic [15:0] DAY_MAX     = 16'h001F;
  localparam logic [15:0] HOUR_MAX    = 16'h0017;
  localparam logic [15:0] MINSEC_MAX  = 16'h003B;
  localparam logic [15:0] LOOP_MAX    = 16'h5208;
  localparam logic [15:0] GAS_SAT     = 16'hFFFF;
  localparam logic [15:0] DAYS_SHORT  = 16'h001E;
  localparam logic [15:0] DAYS_FEB    = 16'h001C;
  localparam logic [15:0] DAYS_LEAP   = 16'h001D;
  localparam int          EXT_SCALE   = 1000;

  // reset values, index = holding register number
  localparam logic [15:0] HOLD_RST [1:7] = '{16'h0000, 16'h0001, 16'h0001, 16'h0000,
                                              16'h0000, 16'h0000, 16'h0000};

  // one-second tick
  localparam int SEC_PERIOD_MS = 1000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SEC_CYCLES    = SEC_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

  typedef struct packed {
    logic        valid;
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        first;
    logic        last;
  } gdm_req_type;

  typedef struct packed {
    logic        valid;
    logic        exc;
    logic [7:0]  code;
    logic [15:0] data;
  } gdm_rsp_type;

  typedef struct packed {
    logic [15:0] year;
    logic [15:0] month;
    logic [15:0] day;
    logic [15:0] hour;
    logic [15:0] minute;
    logic [15:0] second;
  } gdm_time_type;

  typedef enum logic {MW_IDLE, MW_COLLECT} gdm_mw_state_type;

endpackage

// ---- rtl/gdm_register_map.sv ----
// gdm_register_map: register map of the detector, with its running clock.
// assumes requests come decoded from a serial front end on the same clock.
//
// Summary of operation
// RL1 - input registers read-only, read by 0x04
// RL2 - simple gas inputs 1,2 saturate at 65535
// RL3 - extended value is product of pair/1000
// RL4 - extended gas 16-19, laser levels 12-15
// RL5 - holding registers read by 0x03
// RL6 - holding writes by 0x06 or 0x10
// RL7 - holding 1 is year from 2000, 0-200
// RL8 - holding 2 is month, 1-12
// RL9 - holding 3 is day, 1-31
// RL10 - holding 4 is hour, 0-23
// RL11 - holding 5 is minute, 0-59
// RL12 - holding 6 is second, 0-59
// RL13 - receiver holding 7 forced current, 0-21000
// RL14 - valid date/time write updates running clock
// RL15 - master should write 1-6 in one go
// RL16 - out-of-range write dropped with error response
// RL17 - multiple write applied in one update
// RL18 - writes to input registers are refused
module gdm_register_map
  import gdm_pkg::*;
#(
  parameter bit IS_RECEIVER = 1'b1,
  parameter int TICK_CYCLES = SEC_CYCLES
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire gdm_req_type  req,
  output gdm_rsp_type       rsp,
  input  wire logic [31:0]  gas_a_ppm,
  input  wire logic [31:0]  gas_b_ppm,
  input  wire logic [15:0]  ext_words [NUM_EXT],
  input  wire logic [15:0]  laser_one_last_gas_day,
  input  wire logic [15:0]  laser_one_last_gas_hour,
  input  wire logic [15:0]  laser_one_last_gas_minute,
  input  wire logic [15:0]  laser_one_last_gas_second,
  output gdm_time_type      rtc,
  output logic [15:0]       forced_loop_current
);

  gdm_mw_state_type mw_state_q;
  gdm_rsp_type      rsp_q;
  logic [15:0]      hold_q    [1:7];
  logic [15:0]      hold_d    [1:7];
  logic [15:0]      adv       [1:7];
  logic [15:0]      stg_q     [1:7];
  logic [15:0]      stg_next  [1:7];
  logic [7:0]       mask_q;
  logic [7:0]       mask_base;
  logic [7:0]       mask_next;
  logic [7:0]       err_q;
  logic [7:0]       err_base;
  logic [7:0]       err_next;
  logic [7:0]       word_code;
  logic [23:0]      tick_cnt_q;

  function automatic logic val_ok(input logic [15:0] a, input logic [15:0] v);
    case (a)
      HR_YEAR:   val_ok = (v <= YEAR_MAX);                          // RL7
      HR_MONTH:  val_ok = (v >= MONTH_MIN) && (v <= MONTH_MAX);     // RL8
      HR_DAY:    val_ok = (v >= DAY_MIN) && (v <= DAY_MAX);         // RL9
      HR_HOUR:   val_ok = (v <= HOUR_MAX);                          // RL10
      HR_MINUTE: val_ok = (v <= MINSEC_MAX);                        // RL11
      HR_SECOND: val_ok = (v <= MINSEC_MAX);                        // RL12
      HR_LOOP:   val_ok = (v <= LOOP_MAX);                          // RL13
      default:   val_ok = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] days_in(input logic [15:0] m, input logic [15:0] y);
    case (m)
      16'h0002: days_in = (y[1:0] == 2'h0) ? DAYS_LEAP : DAYS_FEB;
      16'h0004, 16'h0006, 16'h0009, 16'h000B: days_in = DAYS_SHORT;
      default: days_in = DAY_MAX;
    endcase
  endfunction

  // request decode
  wire is_rd_hold = req.valid && (req.func == FN_RD_HOLD);
  wire is_rd_in   = req.valid && (req.func == FN_RD_INPUT);
  wire is_wr1     = req.valid && (req.func == FN_WR_SINGLE);
  wire is_wrm     = req.valid && (req.func == FN_WR_MULTI);
  wire is_bad_fn  = req.valid && !(is_rd_hold || is_rd_in || is_wr1 || is_wrm);

  wire [15:0] hold_top   = IS_RECEIVER ? HR_LOOP : HR_SECOND;
  wire        hold_ok    = (req.addr >= HR_YEAR) && (req.addr <= hold_top);
  wire [2:0]  hold_idx   = req.addr[2:0];
  wire [15:0] hold_rdata = (hold_idx == 3'h0) ? 16'h0000 : hold_q[hold_idx];

  // input registers, receiver only
  wire        in_ext    = (req.addr >= IR_EXT_FIRST) && (req.addr <= IR_EXT_LAST);
  wire [2:0]  ext_idx   = 3'(req.addr - IR_EXT_FIRST);
  wire        in_l1     = (req.addr >= IR_L1_GAS_DAY) && (req.addr <= IR_L1_GAS_SEC);
  wire        in_ok     = IS_RECEIVER && ((req.addr == IR_GAS_A) || (req.addr == IR_GAS_B)
                                          || in_ext || in_l1);
  wire [15:0] gas_a_sat = (gas_a_ppm[31:16] != 16'h0000) ? GAS_SAT : gas_a_ppm[15:0]; // RL2
  wire [15:0] gas_b_sat = (gas_b_ppm[31:16] != 16'h0000) ? GAS_SAT : gas_b_ppm[15:0]; // RL2
  wire [15:0] in_rdata  =
      (req.addr == IR_GAS_A)       ? gas_a_sat :
      (req.addr == IR_GAS_B)       ? gas_b_sat :
      in_ext                       ? ext_words[ext_idx] :   // RL3 RL4
      (req.addr == IR_L1_GAS_DAY)  ? laser_one_last_gas_day :
      (req.addr == IR_L1_GAS_HOUR) ? laser_one_last_gas_hour :
      (req.addr == IR_L1_GAS_MIN)  ? laser_one_last_gas_minute :
      laser_one_last_gas_second;

  // write path: single write is a one-word multiple write
  wire wr_word  = is_wr1 || is_wrm;                                               // RL6
  wire wr_start = is_wr1 || req.first || (mw_state_q == MW_IDLE);
  wire wr_end   = is_wr1 || req.last;
  wire word_ok  = hold_ok && val_ok(req.addr, req.wdata);

  assign word_code = !hold_ok ? EXC_ILL_ADDR :                                    // RL18
                     !val_ok(req.addr, req.wdata) ? EXC_ILL_VALUE : EXC_NONE;     // RL16
  assign mask_base = wr_start ? 8'h00 : mask_q;
  assign err_base  = wr_start ? EXC_NONE : err_q;
  assign err_next  = (err_base != EXC_NONE) ? err_base : word_code;
  wire   commit    = wr_word && wr_end && (err_next == EXC_NONE);                 // RL16

  // running clock advance
  wire [23:0] tick_last = 24'(TICK_CYCLES - 1);
  wire        tick      = (tick_cnt_q == tick_last);
  wire        sec_wrap  = tick && (hold_q[6] >= MINSEC_MAX);
  wire        min_wrap  = sec_wrap && (hold_q[5] >= MINSEC_MAX);
  wire        hr_wrap   = min_wrap && (hold_q[4] >= HOUR_MAX);
  wire        day_wrap  = hr_wrap && (hold_q[3] >= days_in(hold_q[2], hold_q[1]));
  wire        mon_wrap  = day_wrap && (hold_q[2] >= MONTH_MAX);

  assign adv[6] = sec_wrap ? HOLD_RST[6] : (tick ? hold_q[6] + 16'h0001 : hold_q[6]);
  assign adv[5] = min_wrap ? HOLD_RST[5] : (sec_wrap ? hold_q[5] + 16'h0001 : hold_q[5]);
  assign adv[4] = hr_wrap ? HOLD_RST[4] : (min_wrap ? hold_q[4] + 16'h0001 : hold_q[4]);
  assign adv[3] = day_wrap ? HOLD_RST[3] : (hr_wrap ? hold_q[3] + 16'h0001 : hold_q[3]);
  assign adv[2] = mon_wrap ? HOLD_RST[2] : (day_wrap ? hold_q[2] + 16'h0001 : hold_q[2]);
  assign adv[1] = !mon_wrap ? hold_q[1] :
                  (hold_q[1] >= YEAR_MAX) ? HOLD_RST[1] : hold_q[1] + 16'h0001;
  assign adv[7] = hold_q[7];

  // staging and commit, one update for all written fields
  for (genvar i = 1; i <= NUM_HOLD; i++) begin : g_hold
    wire hit = word_ok && (req.addr == 16'(i));
    assign stg_next[i]  = (wr_word && hit) ? req.wdata : stg_q[i];
    assign mask_next[i] = mask_base[i] | (wr_word && hit);
    assign hold_d[i]    = (commit && mask_next[i]) ? stg_next[i] : adv[i]; // RL14 RL17
  end
  assign mask_next[0] = 1'b0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 1; i <= NUM_HOLD; i++) begin
        hold_q[i] <= HOLD_RST[i];
        stg_q[i]  <= HOLD_RST[i];
      end
    end else begin
      for (int i = 1; i <= NUM_HOLD; i++) begin
        hold_q[i] <= hold_d[i];
        stg_q[i]  <= stg_next[i];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= 24'h000000;
    end else begin
      tick_cnt_q <= tick ? 24'h000000 : tick_cnt_q + 24'h000001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mw_state_q <= MW_IDLE;
      mask_q     <= 8'h00;
      err_q      <= EXC_NONE;
    end else if (wr_word) begin
      mw_state_q <= wr_end ? MW_IDLE : MW_COLLECT;
      mask_q     <= mask_next;
      err_q      <= err_next;
    end
  end

  // answer, one cycle after the request
  gdm_rsp_type rsp_d;
  always_comb begin
    rsp_d = '0;
    if (is_bad_fn) begin
      rsp_d = '{valid: 1'b1, exc: 1'b1, code: EXC_ILL_FUNC, data: 16'h0000};
    end else if (is_rd_hold) begin                                               // RL5
      rsp_d = '{valid: 1'b1, exc: !hold_ok, code: hold_ok ? EXC_NONE : EXC_ILL_ADDR,
                data: hold_ok ? hold_rdata : 16'h0000};
    end else if (is_rd_in) begin                                                 // RL1
      rsp_d = '{valid: 1'b1, exc: !in_ok, code: in_ok ? EXC_NONE : EXC_ILL_ADDR,
                data: in_ok ? in_rdata : 16'h0000};
    end else if (wr_word && wr_end) begin                                        // RL16
      rsp_d = '{valid: 1'b1, exc: (err_next != EXC_NONE), code: err_next, data: req.wdata};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  assign rsp                 = rsp_q;
  assign rtc                 = '{year: hold_q[1], month: hold_q[2], day: hold_q[3],
                                 hour: hold_q[4], minute: hold_q[5], second: hold_q[6]};
  assign forced_loop_current = hold_q[7];                                        // RL13

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_rd_in(logic [15:0] a);
    is_rd_in && (req.addr == a);
  endsequence

  sequence s_ok_answer;
    rsp.valid && !rsp.exc;
  endsequence

  property p_input_read;
    s_rd_in(IR_L1_GAS_DAY) |=> s_ok_answer ##0 (rsp.data == $past(laser_one_last_gas_day));
  endproperty
  a_input_read: assert property (p_input_read) else $error("input read wrong"); // RL1

  property p_gas_sat;
    s_rd_in(IR_GAS_A) ##0 (gas_a_ppm > 32'h0000FFFF) |=> (rsp.data == GAS_SAT);
  endproperty
  a_gas_sat: assert property (p_gas_sat) else $error("gas not saturated"); // RL2

  property p_ext_pair;
    s_rd_in(IR_EXT_FIRST) |=> s_ok_answer ##0 (rsp.data == $past(ext_words[0]));
  endproperty
  a_ext_pair: assert property (p_ext_pair) else $error("extended word wrong"); // RL4

  property p_hold_read;
    is_rd_hold && (req.addr == HR_MONTH) |=> s_ok_answer ##0 (rsp.data == $past(hold_q[2]));
  endproperty
  a_hold_read: assert property (p_hold_read) else $error("holding read wrong"); // RL5

  property p_single_write;
    is_wr1 && (req.addr == HR_MONTH) && (req.wdata >= MONTH_MIN) && (req.wdata <= MONTH_MAX)
      |=> s_ok_answer ##0 (hold_q[2] == $past(req.wdata));
  endproperty
  a_single_write: assert property (p_single_write) else $error("month write lost"); // RL14

  property p_year_range;
    hold_q[1] <= YEAR_MAX;
  endproperty
  a_year_range: assert property (p_year_range) else $error("year out of range"); // RL7

  property p_time_ranges;
    (hold_q[2] >= MONTH_MIN) && (hold_q[2] <= MONTH_MAX) && (hold_q[3] >= DAY_MIN)
      && (hold_q[3] <= DAY_MAX) && (hold_q[4] <= HOUR_MAX) && (hold_q[5] <= MINSEC_MAX)
      && (hold_q[6] <= MINSEC_MAX);
  endproperty
  a_time_ranges: assert property (p_time_ranges) else $error("time field out of range"); // RL9

  property p_loop_range;
    hold_q[7] <= LOOP_MAX;
  endproperty
  a_loop_range: assert property (p_loop_range) else $error("loop current out of range"); // RL13

  property p_bad_value;
    is_wr1 && (req.addr == HR_HOUR) && (req.wdata > HOUR_MAX) && !min_wrap
      |=> rsp.exc && (rsp.code == EXC_ILL_VALUE) && $stable(hold_q[4]);
  endproperty
  a_bad_value: assert property (p_bad_value) else $error("bad value accepted"); // RL16

  sequence s_multi_end;
    is_wrm && req.last && commit && mask_next[1] && mask_next[6];
  endsequence

  property p_multi_commit;
    s_multi_end |=> (hold_q[1] == $past(stg_next[1])) && (hold_q[6] == $past(stg_next[6]));
  endproperty
  a_multi_commit: assert property (p_multi_commit) else $error("multiple write split"); // RL17

  property p_input_write;
    is_wr1 && (req.addr == IR_L1_GAS_DAY) |=> rsp.exc && (rsp.code == EXC_ILL_ADDR);
  endproperty
  a_input_write: assert property (p_input_write) else $error("input write accepted"); // RL18

  sequence s_clock_quiet;
    !commit && !tick;
  endsequence

  property p_hold_still;
    s_clock_quiet |=> $stable(rtc) && $stable(forced_loop_current);
  endproperty
  a_hold_still: assert property (p_hold_still) else $error("register moved"); // RL16

  property p_gas_pass;
    s_rd_in(IR_GAS_A) ##0 (gas_a_ppm <= 32'h0000FFFF)
      |=> s_ok_answer ##0 (rsp.data == $past(gas_a_ppm[15:0]));
  endproperty
  a_gas_pass: assert property (p_gas_pass) else $error("gas value altered"); // RL2

  property p_loop_read;
    is_rd_hold && (req.addr == HR_LOOP) |=> s_ok_answer ##0 (rsp.data == $past(hold_q[7]));
  endproperty
  a_loop_read: assert property (p_loop_read) else $error("loop current read wrong"); // RL13

  property p_write_echo;
    is_wr1 && word_ok |=> s_ok_answer ##0 (rsp.data == $past(req.wdata));
  endproperty
  a_write_echo: assert property (p_write_echo) else $error("single write not answered"); // RL6

  property p_multi_quiet;
    is_wrm && !req.last |=> !rsp.valid;
  endproperty
  a_multi_quiet: assert property (p_multi_quiet) else $error("answer before last word"); // RL17

  property p_multi_refused;
    is_wrm && req.last && (err_next != EXC_NONE) && !tick
      |=> rsp.exc && (rsp.code == $past(err_next)) && $stable(rtc);
  endproperty
  a_multi_refused: assert property (p_multi_refused) else $error("bad write applied"); // RL16

  property p_bad_func;
    is_bad_fn |=> rsp.valid && rsp.exc && (rsp.code == EXC_ILL_FUNC);
  endproperty
  a_bad_func: assert property (p_bad_func) else $error("unknown function served"); // RL1

  property p_addr_refused;
    is_rd_hold && !hold_ok |=> rsp.exc && (rsp.code == EXC_ILL_ADDR);
  endproperty
  a_addr_refused: assert property (p_addr_refused) else $error("bad address served"); // RL5

  property p_second_step;
    tick && !commit && (hold_q[6] < MINSEC_MAX)
      |=> (hold_q[6] == $past(hold_q[6]) + 16'h0001);
  endproperty
  a_second_step: assert property (p_second_step) else $error("second not advanced"); // RL12

  property p_month_end;
    day_wrap && !mon_wrap && !commit
      |=> (hold_q[3] == DAY_MIN) && (hold_q[2] == $past(hold_q[2]) + 16'h0001);
  endproperty
  a_month_end: assert property (p_month_end) else $error("month end missed"); // RL9

endmodule
